// File: design/ucsad_decoder.sv
/*
 * Alpha-field decoder: turns a record byte stream into one character per output strobe.
 * Assumes the byte source runs on this clock and marks the first and last byte of each field.
 */
`timescale 1ns/1ps
`include "ucsad_consts.svh"

module ucsad_decoder (
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  clk_en,
    input  wire logic                  byte_valid,
    input  ucsad_pkg::ucsad_byte_s     byte_in,
    output logic                       char_valid_q,
    output ucsad_pkg::ucsad_char_s     char_q,
    output logic                       done_q,
    output logic                       done_short_q
);

    ucsad_pkg::ucsad_state_e state_q;
    ucsad_pkg::ucsad_state_e state_d;
    logic                    wide_q;
    logic                    wide_d;
    logic [7:0]              hi_q;
    logic [7:0]              remain_q;
    logic [15:0]             base_q;
    logic                    emit_d;
    logic                    short_d;
    ucsad_pkg::ucsad_char_s  char_d;
    ucsad_pkg::ucsad_char_s  mapped;
    logic                    acc;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic ucsad_pkg::ucsad_char_s gsm_char(input logic [7:0] b);
        ucsad_pkg::ucsad_char_s c;
        c.gsm  = 1'b1;
        c.code = {9'h000, b[6:0]};
        return c;
    endfunction : gsm_char

    function automatic logic is_pad(input logic [7:0] b);
        return b == `UCSAD_PAD_BYTE;
    endfunction : is_pad

    assign acc = clk_en & byte_valid;

    ucsad_char_map u_map (
        .char_byte (byte_in.data),
        .base      (base_q),
        .result    (mapped)
    );

    // ****************************************************************
    // next state and character
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        wide_d  = wide_q;
        emit_d  = 1'b0;
        short_d = 1'b0;
        char_d  = '0;
        if (acc) begin
            if (byte_in.first) begin
                if (byte_in.data == `UCSAD_LEAD_DIRECT) begin
                    state_d = ucsad_pkg::ST_DIRECT_HI;
                end else if (byte_in.data == `UCSAD_LEAD_HALF) begin
                    state_d = ucsad_pkg::ST_COUNT;
                    wide_d  = 1'b0;
                end else if (byte_in.data == `UCSAD_LEAD_WIDE) begin
                    state_d = ucsad_pkg::ST_COUNT;
                    wide_d  = 1'b1;
                end else if (is_pad(byte_in.data)) begin
                    state_d = ucsad_pkg::ST_SKIP;
                end else begin
                    state_d = ucsad_pkg::ST_PLAIN;
                    emit_d  = 1'b1;
                    char_d  = gsm_char(byte_in.data);
                end
            end else begin
                unique case (state_q)
                    ucsad_pkg::ST_LEAD: begin
                        state_d = ucsad_pkg::ST_LEAD;
                    end
                    ucsad_pkg::ST_DIRECT_HI: begin
                        state_d = is_pad(byte_in.data) ? ucsad_pkg::ST_SKIP : ucsad_pkg::ST_DIRECT_LO;
                    end
                    ucsad_pkg::ST_DIRECT_LO: begin
                        state_d     = ucsad_pkg::ST_DIRECT_HI;
                        emit_d      = 1'b1;
                        char_d.gsm  = 1'b0;
                        char_d.code = {hi_q, byte_in.data};
                    end
                    ucsad_pkg::ST_COUNT: begin
                        state_d = (byte_in.data == `UCSAD_COUNT_RST) ? ucsad_pkg::ST_SKIP : ucsad_pkg::ST_BASE_HI;
                    end
                    ucsad_pkg::ST_BASE_HI: begin
                        state_d = wide_q ? ucsad_pkg::ST_BASE_LO : ucsad_pkg::ST_CHARS;
                    end
                    ucsad_pkg::ST_BASE_LO: begin
                        state_d = ucsad_pkg::ST_CHARS;
                    end
                    ucsad_pkg::ST_CHARS: begin
                        emit_d  = 1'b1;
                        char_d  = mapped;
                        state_d = (remain_q == 8'h01) ? ucsad_pkg::ST_SKIP : ucsad_pkg::ST_CHARS;
                    end
                    ucsad_pkg::ST_PLAIN: begin
                        if (is_pad(byte_in.data)) begin
                            state_d = ucsad_pkg::ST_SKIP;
                        end else begin
                            emit_d = 1'b1;
                            char_d = gsm_char(byte_in.data);
                        end
                    end
                    ucsad_pkg::ST_SKIP: begin
                        state_d = ucsad_pkg::ST_SKIP;
                    end
                endcase
            end
            if (byte_in.last) begin
                // a counted field cut off after its lead byte and before its count runs out is reported as short; a lone lead byte is not
                short_d = !byte_in.first && ((state_q == ucsad_pkg::ST_COUNT) ||
                          (state_q == ucsad_pkg::ST_BASE_HI) || (state_q == ucsad_pkg::ST_BASE_LO) ||
                          ((state_q == ucsad_pkg::ST_CHARS) && (remain_q != 8'h01)));
                state_d = ucsad_pkg::ST_LEAD;
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ucsad_pkg::ST_LEAD;
            wide_q  <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            wide_q  <= wide_d;
        end
    end

    // ****************************************************************
    // field registers: high half, count, base
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            hi_q     <= `UCSAD_HI_RST;
            remain_q <= `UCSAD_COUNT_RST;
            base_q   <= `UCSAD_BASE_RST;
        end else if (acc && !byte_in.first) begin
            if (state_q == ucsad_pkg::ST_DIRECT_HI) begin
                hi_q <= byte_in.data;
            end
            if (state_q == ucsad_pkg::ST_COUNT) begin
                remain_q <= byte_in.data;
            end else if (state_q == ucsad_pkg::ST_CHARS) begin
                remain_q <= 8'(remain_q - 8'h01);
            end
            if (state_q == ucsad_pkg::ST_BASE_HI) begin
                // half-page base, high half of full base
                base_q <= wide_q ? {byte_in.data, 8'h00}
                                 : {1'b0, byte_in.data, `UCSAD_HALF_SHIFT'(0)};
            end
            if (state_q == ucsad_pkg::ST_BASE_LO) begin
                base_q <= {base_q[15:8], byte_in.data};
            end
        end
    end

    // ****************************************************************
    // output registers
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            char_valid_q <= 1'b0;
            char_q       <= '0;
            done_q       <= 1'b0;
            done_short_q <= 1'b0;
        end else if (clk_en) begin
            char_valid_q <= emit_d;
            if (emit_d) begin
                char_q <= char_d;
            end
            done_q       <= acc & byte_in.last;
            done_short_q <= short_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_LEAD_DIRECT: assert property (@(posedge clock) disable iff (srst)
        acc && byte_in.first && byte_in.data == 8'h80 && !byte_in.last |=> state_q == ucsad_pkg::ST_DIRECT_HI)
        else $error("lead 80 did not enter pair mode");
    AST_PAIR_ORDER: assert property (@(posedge clock) disable iff (srst)
        acc && !byte_in.first && state_q == ucsad_pkg::ST_DIRECT_LO
        |=> char_valid_q && !char_q.gsm && char_q.code == {$past(hi_q), $past(byte_in.data)})
        else $error("pair not assembled high byte first");
    AST_ODD_SILENT: assert property (@(posedge clock) disable iff (srst)
        acc && !byte_in.first && state_q == ucsad_pkg::ST_DIRECT_HI |=> !char_valid_q)
        else $error("lone byte of a pair produced a character");
    AST_HALF_BASE: assert property (@(posedge clock) disable iff (srst)
        acc && !byte_in.first && state_q == ucsad_pkg::ST_BASE_HI && !wide_q
        |=> base_q == {1'b0, $past(byte_in.data), 7'h00})
        else $error("half-page base misplaced");
    AST_WIDE_BASE: assert property (@(posedge clock) disable iff (srst)
        acc && !byte_in.first && state_q == ucsad_pkg::ST_BASE_HI && wide_q
        ##1 acc && !byte_in.first && state_q == ucsad_pkg::ST_BASE_LO
        |=> base_q == {$past(byte_in.data, 2), $past(byte_in.data)})
        else $error("full base not high byte first");
    AST_OFFSET_CHAR: assert property (@(posedge clock) disable iff (srst)
        acc && !byte_in.first && state_q == ucsad_pkg::ST_CHARS && byte_in.data[7]
        |=> char_valid_q && !char_q.gsm && char_q.code == 16'($past(base_q) + {9'h000, $past(byte_in.data[6:0])}))
        else $error("offset character wrong");
    AST_GSM_CHAR: assert property (@(posedge clock) disable iff (srst)
        acc && !byte_in.first && state_q == ucsad_pkg::ST_CHARS && !byte_in.data[7]
        |=> char_valid_q && char_q.gsm && char_q.code == {9'h000, $past(byte_in.data[6:0])})
        else $error("default-alphabet character wrong");
    AST_COUNT_END: assert property (@(posedge clock) disable iff (srst)
        acc && !byte_in.first && !byte_in.last && state_q == ucsad_pkg::ST_CHARS && remain_q == 8'h01
        |=> state_q == ucsad_pkg::ST_SKIP)
        else $error("decoding did not stop at count");
    AST_PLAIN_PAD: assert property (@(posedge clock) disable iff (srst)
        acc && !byte_in.first && state_q == ucsad_pkg::ST_PLAIN && byte_in.data == 8'hFF |=> !char_valid_q)
        else $error("padding emitted as plain character");
    AST_STROBE_PULSE: assert property (@(posedge clock) disable iff (srst)
        clk_en && !byte_valid |=> !char_valid_q)
        else $error("character strobe without a byte");

endmodule : ucsad_decoder

// File: design/ucsad_consts.svh
/*
 * Constants of the alpha-field decoder: lead codes, padding value and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef UCSAD_CONSTS_SVH
`define UCSAD_CONSTS_SVH

// ****************************************************************
// lead bytes and padding
// ****************************************************************
`define UCSAD_LEAD_DIRECT   8'h80
`define UCSAD_LEAD_HALF     8'h81
`define UCSAD_LEAD_WIDE     8'h82
`define UCSAD_PAD_BYTE      8'hFF

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define UCSAD_TOP_BIT       7
`define UCSAD_HALF_SHIFT    7
`define UCSAD_BASE_RST      16'h0000
`define UCSAD_COUNT_RST     8'h00
`define UCSAD_HI_RST        8'h00

`endif

// File: design/ucsad_pkg.sv
/*
 * Types of the alpha-field decoder: input byte carrier, output character and states.
 * Assumes nothing beyond the constants header.
 */
package ucsad_pkg;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic       first;
        logic       last;
        logic [7:0] data;
    } ucsad_byte_s;

    typedef struct packed {
        logic        gsm;
        logic [15:0] code;
    } ucsad_char_s;

    // ****************************************************************
    // decoder states, one-hot
    // ****************************************************************
    typedef enum logic [8:0] {
        ST_LEAD      = 9'h001,
        ST_DIRECT_HI = 9'h002,
        ST_DIRECT_LO = 9'h004,
        ST_COUNT     = 9'h008,
        ST_BASE_HI   = 9'h010,
        ST_BASE_LO   = 9'h020,
        ST_CHARS     = 9'h040,
        ST_PLAIN     = 9'h080,
        ST_SKIP      = 9'h100
    } ucsad_state_e;

endpackage : ucsad_pkg

// File: design/ucsad_char_map.sv
/*
 * Maps one character byte of a base-pointer field to a default-alphabet character or a code point.
 * Assumes a purely combinational use; the caller registers the result.
 */
`timescale 1ns/1ps
`include "ucsad_consts.svh"

module ucsad_char_map (
    input  wire logic [7:0]          char_byte,
    input  wire logic [15:0]         base,
    output ucsad_pkg::ucsad_char_s   result
);

    logic [15:0] offset_sum;

    // ****************************************************************
    // offset addition
    // ****************************************************************
    // the sum wraps at 16 bits; a well-formed base never carries out
    assign offset_sum = 16'(base + {9'h000, char_byte[6:0]});

    always_comb begin
        result.gsm  = ~char_byte[`UCSAD_TOP_BIT];
        result.code = char_byte[`UCSAD_TOP_BIT] ? offset_sum : {9'h000, char_byte[6:0]};
    end

endmodule : ucsad_char_map

// File: sim/ucsad_src.sv
/*
 * Record byte source that feeds the alpha-field decoder one field at a time.
 * Assumes the bench fills field_q, then calls play; clk_en gates each byte transfer.
 */
`timescale 1ns/1ps

module ucsad_src (
    input  wire logic              clock,
    input  wire logic              clk_en,
    output logic                   byte_valid,
    output ucsad_pkg::ucsad_byte_s byte_in
);
    logic [7:0] field_q[$];

    initial begin
        byte_valid = 1'h0;
        byte_in    = '0;
    end

    // ****************************************************************
    // field playback
    // ****************************************************************
    // padding bytes sent as FF
    task automatic play(input bit close);
        int n;
        n = field_q.size();
        for (int i = 0; i < n; i++) begin
            byte_valid <= 1'h1;
            byte_in    <= {i == 0, close && (i == n - 1), field_q[i]};
            // a byte stands until an enabled edge takes it
            do @(posedge clock); while (clk_en !== 1'h1);
        end
        byte_valid <= 1'h0;
        // released data must not look like a valid repeat
        byte_in    <= {2'h0, ~field_q[n - 1]};
        field_q.delete();
    endtask : play
endmodule : ucsad_src

// File: sim/ucsad_decoder_test.sv
/*
 * Self-checking bench of the alpha-field decoder, one task per scenario.
 * Assumes the design's own assertions run alongside; the byte source model feeds it.
 */
`timescale 1ns/1ps

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module ucsad_decoder_test;
    typedef ucsad_pkg::ucsad_char_s ucsad_cq_t[$];
    typedef logic [7:0]             ucsad_bq_t[$];

    logic                   clock;
    logic                   srst;
    logic                   clk_en;
    logic                   byte_valid;
    ucsad_pkg::ucsad_byte_s byte_in;
    logic                   char_valid_q;
    ucsad_pkg::ucsad_char_s char_q;
    logic                   done_q;
    logic                   done_short_q;
    ucsad_cq_t              got_q;
    // never filled: stands for a field that yields no character
    ucsad_cq_t              none_q;
    int                     done_n;
    int                     short_n;
    int                     error_cnt;
    int                     compares;

    ucsad_decoder u_dut (
        .clock        (clock),
        .srst         (srst),
        .clk_en       (clk_en),
        .byte_valid   (byte_valid),
        .byte_in      (byte_in),
        .char_valid_q (char_valid_q),
        .char_q       (char_q),
        .done_q       (done_q),
        .done_short_q (done_short_q)
    );

    ucsad_src u_src (
        .clock      (clock),
        .clk_en     (clk_en),
        .byte_valid (byte_valid),
        .byte_in    (byte_in)
    );

    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    // ****************************************************************
    // output monitor
    // ****************************************************************
    // a strobe stands while clk_en is low, so count it only at enabled edges
    always @(posedge clock) begin
        if (srst === 1'h0 && clk_en === 1'h1) begin
            if (char_valid_q === 1'h1) got_q.push_back(char_q);
            if (done_q === 1'h1) begin
                done_n++;
                short_n += (done_short_q === 1'h1);
            end
        end
    end

    function automatic ucsad_pkg::ucsad_char_s ch(logic g, logic [15:0] c);
        return {g, c};
    endfunction : ch

    task automatic send(input ucsad_bq_t b, input bit close);
        @(posedge clock);
        u_src.field_q = b;
        u_src.play(close);
    endtask : send

    task automatic judge(input ucsad_cq_t exp, input int dn, input int sh);
        repeat (4) @(posedge clock);
        `CHK(got_q.size(), exp.size())
        for (int i = 0; i < exp.size() && i < got_q.size(); i++) `CHK(got_q[i], exp[i])
        `CHK(done_n, dn)
        if (sh >= 0) `CHK(short_n, sh)
        got_q.delete();
        done_n  = 0;
        short_n = 0;
    endtask : judge

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_direct();
        send('{8'h80, 8'h00, 8'h41, 8'h09, 8'h95, 8'hFF, 8'hFF}, 1);
        judge('{ch(1'h0, 16'h0041), ch(1'h0, 16'h0995)}, 1, 0);
        send('{8'h80, 8'h12, 8'h34, 8'hFF}, 1);
        judge('{ch(1'h0, 16'h1234)}, 1, 0);
    endtask : t_direct

    task automatic t_half();
        send('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h7F, 8'hFF}, 1);
        judge('{ch(1'h1, 16'h0053), ch(1'h0, 16'h0995), ch(1'h0, 16'h09A6),
                ch(1'h1, 16'h007F), ch(1'h0, 16'h09FF)}, 1, 0);
        send('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95}, 1);
        judge('{ch(1'h1, 16'h0053), ch(1'h0, 16'h0995)}, 1, 1);
        // bytes after the count are padding and must stay silent
        send('{8'h81, 8'h02, 8'h13, 8'h53, 8'h95, 8'hFF, 8'hFF}, 1);
        judge('{ch(1'h1, 16'h0053), ch(1'h0, 16'h0995)}, 1, 0);
    endtask : t_half

    task automatic t_wide();
        send('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31}, 1);
        judge('{ch(1'h1, 16'h002D), ch(1'h0, 16'h0532), ch(1'h0, 16'h0583),
                ch(1'h1, 16'h002D), ch(1'h1, 16'h0031)}, 1, 0);
        // base near the top of the code space wraps
        send('{8'h82, 8'h02, 8'hFF, 8'hF0, 8'hFF, 8'h85}, 1);
        judge('{ch(1'h0, 16'h006F), ch(1'h0, 16'hFFF5)}, 1, 0);
        // field cut inside the base pointer counts as short
        send('{8'h82, 8'h03, 8'h05}, 1);
        judge(none_q, 1, 1);
    endtask : t_wide

    task automatic t_plain();
        send('{8'hC1, 8'h42, 8'hFF, 8'h43}, 1);
        judge('{ch(1'h1, 16'h0041), ch(1'h1, 16'h0042)}, 1, 0);
    endtask : t_plain

    task automatic t_abort();
        send('{8'h81, 8'h05, 8'h13, 8'h53}, 0);
        send('{8'h41}, 1);
        judge('{ch(1'h1, 16'h0053), ch(1'h1, 16'h0041)}, 1, 0);
        send('{8'h81, 8'h00, 8'h13, 8'h53}, 1);
        judge(none_q, 1, 0);
    endtask : t_abort

    task automatic t_stall();
        fork
            send('{8'h80, 8'h0A, 8'hBC, 8'h00, 8'h30, 8'hFF}, 1);
            begin
                repeat (3) @(posedge clock);
                clk_en <= 1'h0;
                repeat (3) @(posedge clock);
                clk_en <= 1'h1;
            end
        join
        judge('{ch(1'h0, 16'h0ABC), ch(1'h0, 16'h0030)}, 1, 0);
    endtask : t_stall

    // ****************************************************************
    // run control
    // ****************************************************************
    task automatic final_report();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    initial begin
        #20000;
        error_cnt++;
        final_report();
    end

    initial begin
        srst   = 1'h1;
        clk_en = 1'h1;
        repeat (4) @(posedge clock);
        srst <= 1'h0;
        t_direct();
        t_half();
        t_wide();
        t_plain();
        t_abort();
        t_stall();
        final_report();
    end
endmodule : ucsad_decoder_test
